// ---- iacg_clk_div.sv ----
// Glitch-free clock divider driven by source edge pulses
`timescale 1ns/1ps

module iacg_clk_div #(
    parameter logic [2:0] RST_HALF = 3'h1
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_src_edge,
    input  wire logic [2:0] i_half,
    output logic            o_clk
);

    logic [2:0] cnt_r;
    logic [2:0] half_r;
    logic       clk_r;

    // New half period is only taken at a toggle, so no runt phase
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cnt_r  <= 3'h0;
            half_r <= RST_HALF;
            clk_r  <= 1'b0;
        end else if (i_src_edge) begin
            if (cnt_r == half_r - 3'h1) begin
                cnt_r  <= 3'h0;
                clk_r  <= ~clk_r;
                half_r <= i_half;
            end else begin
                cnt_r <= cnt_r + 3'h1;
            end
        end
    end

    assign o_clk = clk_r;

    default clocking dc @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    toggle_time_a: assert property (
        $changed(clk_r) |->
            $past(i_src_edge) && ($past(cnt_r) == $past(half_r) - 3'h1))
        else $error("divider toggled off its count");

    half_hold_a: assert property (
        !$changed(clk_r) |-> $stable(half_r))
        else $error("divider period changed inside a phase");

endmodule

// ---- iacg_osc_model.sv ----
// Oscillator and strap model standing outside the clock generator
`timescale 1ns/1ps

module iacg_osc_model #(
    parameter int CPU_HALF = 20,
    parameter int BUS_HALF = 24,
    parameter int REF_HALF = 32
) (
    input  wire logic i_fitted,
    input  wire logic i_pin_level,
    output logic      o_cpu_osc,
    output logic      o_bus_pin,
    output logic      o_ref_osc
);
    logic bus_osc;

    // Offset keeps oscillator edges away from core clock edges
    initial begin
        o_cpu_osc = 1'b0;
        o_ref_osc = 1'b0;
        bus_osc = 1'b0;
        #3;
        fork
            forever #CPU_HALF o_cpu_osc = ~o_cpu_osc;
            forever #BUS_HALF bus_osc = ~bus_osc;
            forever #REF_HALF o_ref_osc = ~o_ref_osc;
        join
    end

    // Without an oscillator the board drives a plain level
    assign o_bus_pin = i_fitted ? bus_osc : i_pin_level;
endmodule

// ---- iacg_pkg.sv ----
// Types shared by the clock generator
package iacg_pkg;

    typedef enum logic {
        IACG_IDLE   = 1'b0,
        IACG_CPURST = 1'b1
    } iacg_cpu_st_t;

endpackage

// ---- iacg_regs.svh ----
// Register map, field positions, reset values and timing counts
`ifndef IACG_REGS_SVH
`define IACG_REGS_SVH

// ****************************************************************
// I/O ports
// ****************************************************************
`define IACG_PORT_INDEX     16'h00EC
`define IACG_PORT_DATA      16'h00ED
`define IACG_PORT_SLOW      16'h00F4
`define IACG_PORT_FULL      16'h00F5

// ****************************************************************
// Register indexes behind the data port
// ****************************************************************
`define IACG_IDX_CLOCK_CONTROL_REG     8'h06
`define IACG_IDX_MISC       8'h07
`define IACG_IDX_TURBO      8'h08
`define IACG_IDX_FBASE      8'h0B

// ****************************************************************
// Field positions
// ****************************************************************
`define IACG_CTL_FAST_REGION_ENABLE       7
`define IACG_CTL_CPU_HI     6
`define IACG_CTL_CPU_LO     5
`define IACG_CTL_FAST_HI    4
`define IACG_CTL_FAST_LO    3
`define IACG_CTL_SEL        2
`define IACG_CTL_SLOW_HI    1
`define IACG_CTL_SLOW_LO    0
`define IACG_MISC_SLOW_DIS  3
`define IACG_TURBO_BIT      4

// ****************************************************************
// Reset values
// ****************************************************************
`define IACG_RST_FBASE      8'h00
`define IACG_RST_FAST_REGION_ENABLE       1'b0
`define IACG_RST_CPU_DIV    2'h0
`define IACG_RST_FAST_DIV   2'h3
`define IACG_RST_SLOW_DIV   2'h3
`define IACG_RST_SEL        1'b0
`define IACG_RST_SLOW_DIS   1'b0
`define IACG_RST_RDATA      8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define IACG_CLK_MHZ        125
`define IACG_CPU_RST_US     1000
`define IACG_CPU_RST_CYC    (`IACG_CPU_RST_US * `IACG_CLK_MHZ)
`define IACG_REF_HALF       3'h6
`define IACG_SLOT_HALF      3'h1

`endif

// ---- iacg_top.sv ----
// CPU, ISA, slot and timer clock generation with register access
`timescale 1ns/1ps
`include "iacg_regs.svh"

module iacg_top #(
    parameter int CPU_RST_CYCLES = `IACG_CPU_RST_CYC,
    parameter int RST_CW         = 17
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_cpu_double_clock_in,
    input  wire logic        i_bus_oscillator_in,
    input  wire logic        i_ref_osc_in,
    input  wire logic        i_bus_osc_fitted,
    input  wire logic        i_turbo,
    input  wire logic        i_io_wr,
    input  wire logic        i_io_rd,
    input  wire logic [15:0] i_io_addr,
    input  wire logic [7:0]  i_io_wdata,
    output logic      [7:0]  o_io_rdata,
    input  wire logic        i_mem_cycle,
    input  wire logic        i_master_cycle,
    input  wire logic [31:0] i_mem_addr,
    output logic             o_cpu_clk,
    output logic             o_isa_clk,
    output logic             o_slot_clk,
    output logic             o_timer_clk,
    output logic             o_cpu_reset,
    output logic             o_slow_mode
);

    // ************************************************************
    // Divider decode
    // ************************************************************
    // Half period in source edges; codes step 1, 2, 3, 4 or 2, 3, 4, 6
    function automatic logic [2:0] iacg_half(input logic [1:0] code,
                                             input logic       slow_tclk);
        logic [2:0] h;
        h = {1'b0, code} + 3'h1;
        if (slow_tclk) begin
            h = (code == 2'h3) ? 3'h6 : h + 3'h1;
        end
        return h;
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Bits: 0 cpu osc, 1 bus osc, 2 ref osc, 3 fitted strap, 4 turbo
    logic [4:0] pin_s1_r;
    logic [4:0] pin_s2_r;
    logic [2:0] osc_prev_r;
    logic [2:0] osc_edge;

    // Runs through reset so the strap is settled before release
    always_ff @(posedge i_core_clk) begin
        pin_s1_r   <= {i_turbo, i_bus_osc_fitted, i_ref_osc_in,
                       i_bus_oscillator_in, i_cpu_double_clock_in};
        pin_s2_r   <= pin_s1_r;
        osc_prev_r <= pin_s2_r[2:0];
    end

    assign osc_edge = pin_s2_r[2:0] & ~osc_prev_r;

    // Strap is caught while reset is held
    logic fitted_r;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            fitted_r <= pin_s2_r[3];
        end
    end

    // ************************************************************
    // Register access
    // ************************************************************
    logic [7:0] index_r;
    logic [7:0] fbase_r;
    logic       fb_en_r;
    logic [1:0] cpu_div_r;
    logic [1:0] fast_div_r;
    logic [1:0] slow_div_r;
    logic       sel_r;
    logic       slow_dis_r;
    logic       wr_data;
    logic       ctl_wr;
    logic       sel_view;

    assign wr_data  = i_io_wr && (i_io_addr == `IACG_PORT_DATA);
    assign ctl_wr   = wr_data && (index_r == `IACG_IDX_CLOCK_CONTROL_REG);
    assign sel_view = fitted_r ? sel_r : pin_s2_r[1];

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            index_r <= 8'h00;
        end else if (i_io_wr && (i_io_addr == `IACG_PORT_INDEX)) begin
            index_r <= i_io_wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            fb_en_r    <= `IACG_RST_FAST_REGION_ENABLE;
            cpu_div_r  <= `IACG_RST_CPU_DIV;
            fast_div_r <= `IACG_RST_FAST_DIV;
            slow_div_r <= `IACG_RST_SLOW_DIV;
            sel_r      <= `IACG_RST_SEL;
        end else if (ctl_wr) begin
            fb_en_r    <= i_io_wdata[`IACG_CTL_FAST_REGION_ENABLE];
            cpu_div_r  <= i_io_wdata[`IACG_CTL_CPU_HI:`IACG_CTL_CPU_LO];
            fast_div_r <= i_io_wdata[`IACG_CTL_FAST_HI:`IACG_CTL_FAST_LO];
            slow_div_r <= i_io_wdata[`IACG_CTL_SLOW_HI:`IACG_CTL_SLOW_LO];
            if (fitted_r) begin
                sel_r <= i_io_wdata[`IACG_CTL_SEL];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            fbase_r <= `IACG_RST_FBASE;
        end else if (wr_data && (index_r == `IACG_IDX_FBASE)) begin
            fbase_r <= i_io_wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            slow_dis_r <= `IACG_RST_SLOW_DIS;
        end else if (wr_data && (index_r == `IACG_IDX_MISC)) begin
            slow_dis_r <= i_io_wdata[`IACG_MISC_SLOW_DIS];
        end
    end

    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        case (index_r)
            `IACG_IDX_CLOCK_CONTROL_REG: rd_mux = {fb_en_r, cpu_div_r, fast_div_r,
                                        sel_view, slow_div_r};
            `IACG_IDX_FBASE:  rd_mux = fbase_r;
            `IACG_IDX_MISC:   rd_mux[`IACG_MISC_SLOW_DIS] = slow_dis_r;
            `IACG_IDX_TURBO:  rd_mux[`IACG_TURBO_BIT] = pin_s2_r[4];
            default:          rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_io_rdata <= `IACG_RST_RDATA;
        end else if (i_io_rd && (i_io_addr == `IACG_PORT_DATA)) begin
            o_io_rdata <= rd_mux;
        end else if (i_io_rd && (i_io_addr == `IACG_PORT_INDEX)) begin
            o_io_rdata <= index_r;
        end
    end

    // ************************************************************
    // CPU clock rate and CPU-only reset
    // ************************************************************
    iacg_pkg::iacg_cpu_st_t state_r;
    logic [RST_CW-1:0]      rst_cnt_r;
    logic [1:0]             cur_code_r;
    logic [1:0]             pend_code_r;
    logic                   slow_mode_r;
    logic                   wr_full;
    logic                   wr_slow;
    logic                   rate_wr;
    logic                   rate_req;
    logic [1:0]             tgt_code;

    assign wr_full = i_io_wr && (i_io_addr == `IACG_PORT_FULL);
    assign wr_slow = i_io_wr && (i_io_addr == `IACG_PORT_SLOW) && !slow_dis_r;

    always_comb begin
        tgt_code = cur_code_r;
        if (wr_full) begin
            tgt_code = 2'h0;
        end else if (wr_slow) begin
            tgt_code = cpu_div_r;
        end else if (ctl_wr && slow_mode_r) begin
            tgt_code = i_io_wdata[`IACG_CTL_CPU_HI:`IACG_CTL_CPU_LO];
        end
    end

    assign rate_req = wr_full || wr_slow || (ctl_wr && slow_mode_r);
    assign rate_wr  = rate_req && (tgt_code != pend_code_r);

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            slow_mode_r <= 1'b0;
        end else if (wr_full) begin
            slow_mode_r <= 1'b0;
        end else if (wr_slow) begin
            slow_mode_r <= 1'b1;
        end
    end

    // Reset goes out one cycle before the new rate is applied
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_r     <= iacg_pkg::IACG_IDLE;
            rst_cnt_r   <= '0;
            cur_code_r  <= `IACG_RST_CPU_DIV;
            pend_code_r <= `IACG_RST_CPU_DIV;
        end else begin
            case (state_r)
                iacg_pkg::IACG_IDLE: begin
                    if (tgt_code != cur_code_r) begin
                        state_r     <= iacg_pkg::IACG_CPURST;
                        rst_cnt_r   <= '0;
                        pend_code_r <= tgt_code;
                    end
                end
                iacg_pkg::IACG_CPURST: begin
                    if (rst_cnt_r == '0) begin
                        cur_code_r <= pend_code_r;
                    end
                    if (rate_wr) begin
                        rst_cnt_r   <= '0;
                        pend_code_r <= tgt_code;
                    end else if (rst_cnt_r ==
                                 RST_CW'(CPU_RST_CYCLES - 1)) begin
                        state_r <= iacg_pkg::IACG_IDLE;
                    end else begin
                        rst_cnt_r <= rst_cnt_r + 1'b1;
                    end
                end
                default: state_r <= iacg_pkg::IACG_IDLE;
            endcase
        end
    end

    assign o_cpu_reset = (state_r == iacg_pkg::IACG_CPURST);
    assign o_slow_mode = slow_mode_r;

    // Turbo input does not reach the CPU divider
    iacg_clk_div u_cpu_div (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_src_edge (osc_edge[0]),
        .i_half     (iacg_half(cur_code_r, 1'b0)),
        .o_clk      (o_cpu_clk)
    );

    // ************************************************************
    // ISA system clock
    // ************************************************************
    logic region_hit;
    logic isa_fast;
    logic isa_edge;

    assign region_hit = fb_en_r && i_mem_cycle && !i_master_cycle
                        && (i_mem_addr[23:16] == fbase_r)
                        && !i_mem_addr[31] && !i_mem_addr[29]
                        && !i_mem_addr[25] && !i_mem_addr[24];
    assign isa_fast   = region_hit || sel_view;
    assign isa_edge   = fitted_r ? osc_edge[1] : osc_edge[0];

    iacg_clk_div #(
        .RST_HALF (3'h4)
    ) u_isa_div (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_src_edge (isa_edge),
        .i_half     (isa_fast ? iacg_half(fast_div_r, 1'b0)
                              : iacg_half(slow_div_r, !fitted_r)),
        .o_clk      (o_isa_clk)
    );

    // ************************************************************
    // Fixed clocks
    // ************************************************************
    iacg_clk_div #(
        .RST_HALF (`IACG_SLOT_HALF)
    ) u_slot_div (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_src_edge (osc_edge[0]),
        .i_half     (`IACG_SLOT_HALF),
        .o_clk      (o_slot_clk)
    );

    iacg_clk_div #(
        .RST_HALF (`IACG_REF_HALF)
    ) u_ref_div (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_src_edge (osc_edge[2]),
        .i_half     (`IACG_REF_HALF),
        .o_clk      (o_timer_clk)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking dc @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence rst_before_rate;
        o_cpu_reset && $stable(cur_code_r);
    endsequence

    sequence rate_in_reset;
        o_cpu_reset && (cur_code_r == $past(pend_code_r));
    endsequence

    por_defaults_a: assert property (
        $fell(i_sys_rst) |-> (fast_div_r == 2'h3) && (slow_div_r == 2'h3)
            && (cur_code_r == 2'h0) && (cpu_div_r == 2'h0))
        else $error("reset values wrong on divider fields");

    por_region_a: assert property (
        $fell(i_sys_rst) |-> !fb_en_r && (fbase_r == 8'h00)
            && (!fitted_r || !sel_r))
        else $error("reset values wrong on region or select");

    sel_write_a: assert property (
        fitted_r && ctl_wr |=> sel_r == $past(i_io_wdata[`IACG_CTL_SEL]))
        else $error("select bit did not take written value");

    sel_pin_a: assert property (
        !fitted_r |-> sel_view == pin_s2_r[1] ##1 $stable(sel_r))
        else $error("select bit not tied to pin without oscillator");

    region_fast_a: assert property (
        fb_en_r && i_mem_cycle && !i_master_cycle
            && (i_mem_addr[23:16] == fbase_r)
            && ((i_mem_addr[31:24] & 8'hA3) == 8'h00) |-> isa_fast)
        else $error("region hit did not force fast divider");

    addr_mask_a: assert property (
        (i_mem_addr[31] || i_mem_addr[29] || i_mem_addr[25]
            || i_mem_addr[24]) |-> !region_hit)
        else $error("region matched with a masked address bit set");

    master_slow_a: assert property (
        i_master_cycle && !sel_view |-> !isa_fast)
        else $error("master cycle reached fast divider");

    rate_reset_a: assert property (
        (state_r == iacg_pkg::IACG_IDLE) && (tgt_code != cur_code_r)
            |=> rst_before_rate ##1 rate_in_reset)
        else $error("CPU reset did not precede rate change");

    reset_hold_a: assert property (
        $rose(o_cpu_reset) |-> o_cpu_reset [*8])
        else $error("CPU reset shorter than minimum");

    reset_len_a: assert property (
        $fell(o_cpu_reset) |->
            $past(rst_cnt_r) == RST_CW'(CPU_RST_CYCLES - 1))
        else $error("CPU reset ended off its count");

    full_speed_a: assert property (
        wr_full |=> !slow_mode_r ##[1:2] (cur_code_r == 2'h0))
        else $error("full speed write did not restore divide by two");

    slow_block_a: assert property (
        i_io_wr && (i_io_addr == `IACG_PORT_SLOW) && slow_dis_r
            && !slow_mode_r |=> !slow_mode_r)
        else $error("slow mode entered while disabled");

    turbo_read_a: assert property (
        $changed(pin_s2_r[4]) |-> $stable(cur_code_r)
            || $past(o_cpu_reset))
        else $error("turbo level moved CPU divider");

endmodule

// ---- iacg_top_tb.sv ----
// Directed testbench for the CPU and ISA clock generator
`timescale 1ns/1ps
`include "iacg_regs.svh"

module iacg_top_tb;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        clk;
    logic        rst;
    logic        cosc;
    logic        bpin;
    logic        rosc;
    logic        fit;
    logic        lvl;
    logic        turbo;
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdat;
    logic [7:0]  rdat;
    logic        mcyc;
    logic        mst;
    logic [31:0] maddr;
    logic [5:0]  clks;
    int          fails;
    int          checks_done;

    iacg_osc_model osc_u (.i_fitted(fit), .i_pin_level(lvl),
        .o_cpu_osc(cosc), .o_bus_pin(bpin), .o_ref_osc(rosc));

    iacg_top #(.CPU_RST_CYCLES(16)) dut_u (.i_core_clk(clk),
        .i_sys_rst(rst), .i_cpu_double_clock_in(cosc),
        .i_bus_oscillator_in(bpin), .i_ref_osc_in(rosc),
        .i_bus_osc_fitted(fit), .i_turbo(turbo), .i_io_wr(wr),
        .i_io_rd(rd), .i_io_addr(addr), .i_io_wdata(wdat),
        .o_io_rdata(rdat), .i_mem_cycle(mcyc), .i_master_cycle(mst),
        .i_mem_addr(maddr), .o_cpu_clk(clks[0]), .o_isa_clk(clks[1]),
        .o_slot_clk(clks[2]), .o_timer_clk(clks[3]),
        .o_cpu_reset(clks[4]), .o_slow_mode(clks[5]));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input logic f);
        @(negedge clk);
        rst = 1'b1;
        fit = f;
        repeat (12) @(negedge clk);
        rst = 1'b0;
    endtask

    task automatic pwr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdat = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic rwr(input logic [7:0] i, input logic [7:0] d);
        pwr(`IACG_PORT_INDEX, i);
        pwr(`IACG_PORT_DATA, d);
    endtask

    task automatic prd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        d = rdat;
    endtask

    task automatic rrd(input logic [7:0] i, output logic [7:0] d);
        pwr(`IACG_PORT_INDEX, i);
        prd(`IACG_PORT_DATA, d);
    endtask

    // Cycles between two rises, skipping the one after a change
    task automatic period(input int s, input int exp);
        int n;
        int k;
        logic p;
        for (k = 0; k < 3; k++) begin
            p = clks[s];
            for (n = 1; n < 3000; n++) begin
                @(negedge clk);
                if (p === 1'b0 && clks[s] === 1'b1) break;
                p = clks[s];
            end
        end
        check(n, exp);
    endtask

    // Port write, then length of the CPU-only reset that follows
    task automatic rate(input logic [15:0] a, input logic [7:0] d,
                        input int exp);
        int n;
        pwr(a, d);
        n = 0;
        while (clks[4] === 1'b1 && n < 40) begin
            n++;
            @(negedge clk);
        end
        check(n, exp);
    endtask

    initial begin
        #200000;
        fails++;
        conclude();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        logic [7:0] v;
        int         c;
        rst = 1'b1;
        fit = 1'b1;
        lvl = 1'b0;
        turbo = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdat = 8'h00;
        mcyc = 1'b0;
        mst = 1'b0;
        maddr = 32'h0000_0000;
        fails = 0;
        checks_done = 0;
        do_reset(1'b1);
        rrd(`IACG_IDX_CLOCK_CONTROL_REG, v);
        check(v, 8'h1B);
        rrd(`IACG_IDX_FBASE, v);
        check(v, 8'h00);
        period(0, 10);
        period(3, 96);
        period(1, 48);
        rwr(8'h0C, 8'h5A);
        rrd(8'h0C, v);
        check(v, 8'h00);
        prd(`IACG_PORT_INDEX, v);
        check(v, 8'h0C);
        for (c = 0; c < 4; c++) begin
            rwr(`IACG_IDX_CLOCK_CONTROL_REG, {5'h03, 1'b0, c[1:0]});
            period(1, 12 * c + 12);
            rwr(`IACG_IDX_CLOCK_CONTROL_REG, {3'h0, c[1:0], 3'h7});
            period(1, 12 * c + 12);
        end
        pwr(`IACG_PORT_INDEX, `IACG_IDX_CLOCK_CONTROL_REG);
        rate(`IACG_PORT_DATA, 8'h3B, 0);
        period(0, 10);
        rate(`IACG_PORT_SLOW, 8'h00, 16);
        check(clks[5], 1'b1);
        period(0, 20);
        period(2, 10);
        turbo = 1'b1;
        rrd(`IACG_IDX_TURBO, v);
        check(v & 8'h10, 8'h10);
        period(0, 20);
        turbo = 1'b0;
        rrd(`IACG_IDX_TURBO, v);
        check(v & 8'h10, 8'h00);
        pwr(`IACG_PORT_INDEX, `IACG_IDX_CLOCK_CONTROL_REG);
        rate(`IACG_PORT_DATA, 8'h7B, 16);
        period(0, 40);
        rate(`IACG_PORT_FULL, 8'h00, 16);
        check(clks[5], 1'b0);
        period(0, 10);
        rate(`IACG_PORT_FULL, 8'h00, 0);
        rwr(`IACG_IDX_MISC, 8'h08);
        rrd(`IACG_IDX_MISC, v);
        check(v, 8'h08);
        rate(`IACG_PORT_SLOW, 8'h00, 0);
        period(0, 10);
        rwr(`IACG_IDX_FBASE, 8'h0A);
        rwr(`IACG_IDX_CLOCK_CONTROL_REG, 8'h83);
        rrd(`IACG_IDX_FBASE, v);
        check(v, 8'h0A);
        @(negedge clk);
        maddr = 32'h000A_1234;
        mcyc = 1'b1;
        period(1, 12);
        mst = 1'b1;
        period(1, 48);
        mst = 1'b0;
        maddr = 32'h010A_0000;
        period(1, 48);
        maddr = 32'h400A_0000;
        period(1, 12);
        maddr = 32'h800A_0000;
        period(1, 48);
        maddr = 32'h200A_0000;
        period(1, 48);
        maddr = 32'h020A_0000;
        period(1, 48);
        maddr = 32'h000B_0000;
        period(1, 48);
        mcyc = 1'b0;
        period(1, 48);
        do_reset(1'b0);
        rrd(`IACG_IDX_CLOCK_CONTROL_REG, v);
        check(v, 8'h1B);
        period(1, 60);
        for (c = 0; c < 4; c++) begin
            rwr(`IACG_IDX_CLOCK_CONTROL_REG, {5'h03, 1'b1, c[1:0]});
            period(1, (c == 3) ? 60 : 10 * c + 20);
        end
        lvl = 1'b1;
        for (c = 0; c < 4; c++) begin
            rwr(`IACG_IDX_CLOCK_CONTROL_REG, {3'h0, c[1:0], 3'h3});
            period(1, 10 * c + 10);
        end
        rrd(`IACG_IDX_CLOCK_CONTROL_REG, v);
        check(v, 8'h1F);
        conclude();
    end
endmodule
